// ==== core/ifd_pkg.sv ====
// Package for the instruction format decoder: classes, field positions and reset values
`default_nettype none
package ifd_pkg;
   // Instruction class codes
   typedef enum logic [3:0] {
      IFD_DATA_PROC = 4'h0,
      IFD_MULTIPLY = 4'h1,
      IFD_MUL_LONG = 4'h2,
      IFD_STATUS_READ = 4'h3,
      IFD_STATUS_WR_IMM = 4'h4,
      IFD_STATUS_WR_REG = 4'h5,
      IFD_BRANCH_EXCH = 4'h6,
      IFD_LOAD_STORE = 4'h7,
      IFD_HALF_SIGNED = 4'h8,
      IFD_SWAP = 4'h9,
      IFD_LOAD_STORE_MULT = 4'ha,
      IFD_COPROC_DATA = 4'hb,
      IFD_COPROC_XFER = 4'hc,
      IFD_COPROC_LS = 4'hd,
      IFD_BRANCH = 4'he,
      IFD_SOFT_INT = 4'hf
   } ifd_class_t;

   // Field positions
   localparam int IFD_RD_LSB = 12;
   localparam int IFD_RN_LSB = 16;
   localparam int IFD_CPID_LSB = 8;
   localparam int IFD_SBIT = 20;
   localparam int IFD_SPSR_BIT = 22;
   localparam int IFD_IMM_BIT = 25;
   localparam int IFD_OFS_WIDTH = 24;
   localparam int IFD_CP_OFS_WIDTH = 8;
   // Values after reset
   localparam logic [31:0] IFD_WORD_RESET = 32'h0000_0000;
   localparam logic [3:0] IFD_REG_RESET = 4'h0;
   // Pipeline latency of the decoder in cycles
   localparam int IFD_LATENCY = 1;
endpackage : ifd_pkg
`default_nettype wire

// ==== core/ifd_decoder.sv ====
// Instruction format decoder: classifies a 32-bit word and extracts its fields
// How it works
// RULE1: Bits 27:25 = 101 is branch; bit 24 saves return; 24-bit signed word offset.
// RULE2: Bits 27:25 = 110 is coprocessor load/store with flags, ids and 8-bit offset.
// RULE3: 00010 with bits 21:20 = 00 reads a status register; bit 22 picks saved one.
// RULE4: 00110 with bits 21:20 = 10 writes rotated immediate into status, under mask.
// RULE5: 00010, bits 21:20 = 10, bit 4 clear moves operand_reg into status, under mask.
// RULE6: Immediates are 8 bits rotated right by twice the 4-bit rotate field.
// RULE7: Some unallocated codes like multiply with bit 6 set raise no trap.
// RULE8: User-privilege access only with post-indexing; uses user-mode translation.
// RULE9: Bit 20 of data-processing or multiply requests a flag update.
// RULE10: Register fields index a bank of 31 registers of 32 bits.
// RULE11: Three coprocessor classes routed with coproc_id to the coprocessor port.
// RULE12: Bits 27:26 = 00 otherwise is data processing; bit 25 immediate, 24:21 opcode.
// RULE13: 011 with bit 4 set is undefined and traps; clear is register-offset load/store.
`default_nettype none
module ifd_decoder #(
   parameter int REG_COUNT = 31,
   parameter int DATA_WIDTH = 32
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   output logic dec_valid,
   output ifd_pkg::ifd_class_t dec_class,
   output logic [3:0] cond_code,
   output logic [3:0] opcode,
   output logic imm_operand,
   output logic flag_update,
   output logic [3:0] base_reg,
   output logic [3:0] dest_reg,
   output logic [3:0] operand_reg,
   output logic [3:0] shift_reg,
   output logic [DATA_WIDTH-1:0] imm_value,
   output logic [31:0] branch_offset,
   output logic branch_and_save_return,
   output logic saved_status_select,
   output logic [3:0] field_mask,
   output logic index_before_use,
   output logic add_offset_flag,
   output logic byte_or_size_flag,
   output logic base_update,
   output logic load_flag,
   output logic user_privilege_access,
   output logic [3:0] coproc_id,
   output logic [3:0] coproc_dest,
   output logic [7:0] coproc_offset,
   output logic coproc_request,
   output logic [15:0] reg_list,
   output logic undef_trap
);

   // Rotate an 8-bit value right by twice the rotate field
   function automatic logic [31:0] ifd_rot_imm(input logic [11:0] f);
      logic [63:0] dbl;
      logic [4:0] amt;
      dbl = '0;
      amt = {f[11:8], 1'b0};
      dbl = {24'h00_0000, f[7:0], 24'h00_0000, f[7:0]};
      ifd_rot_imm = dbl[amt +: 32];
   endfunction : ifd_rot_imm

   // Group test on bits 27:23 and 21:20, shared by status move forms
   function automatic logic ifd_status_form(input logic [31:0] w, input logic [4:0] top,
                                            input logic [1:0] mid);
      ifd_status_form = (w[27:23] == top) && (w[21:20] == mid);
   endfunction : ifd_status_form

   logic [31:0] w;
   ifd_pkg::ifd_class_t cls;
   logic undef_next;
   logic is_mult;
   logic is_mlong;
   logic is_swap;
   logic is_bx;
   logic is_half;

   assign w = instr_word;
   // Multiply pattern ignores bit 6 (long multiply does not): such words stay multiply, no trap
   assign is_mult = (w[27:22] == 6'h00) && ({w[7], w[5:4]} == 3'h5); // [RULE7]
   assign is_mlong = (w[27:23] == 5'h01) && (w[7:4] == 4'h9);
   assign is_swap = (w[27:23] == 5'h02) && (w[21:20] == 2'h0) && (w[11:4] == 8'h09);
   assign is_bx = (w[27:4] == 24'h12_fff1);
   assign is_half = (w[27:25] == 3'h0) && w[7] && w[4] && (w[6:5] != 2'h0);

   // Classification; priority runs from most specific pattern to least
   always_comb begin
      cls = ifd_pkg::IFD_DATA_PROC;
      undef_next = 1'b0;
      if (w[27:25] == 3'h5) begin
         cls = ifd_pkg::IFD_BRANCH; // [RULE1]
      end else if (w[27:25] == 3'h6) begin
         cls = ifd_pkg::IFD_COPROC_LS; // [RULE2] [RULE11]
      end else if (w[27:24] == 4'hf) begin
         cls = ifd_pkg::IFD_SOFT_INT;
      end else if (w[27:24] == 4'he) begin
         cls = w[4] ? ifd_pkg::IFD_COPROC_XFER : ifd_pkg::IFD_COPROC_DATA; // [RULE11]
      end else if (w[27:25] == 3'h4) begin
         cls = ifd_pkg::IFD_LOAD_STORE_MULT;
      end else if (w[27:25] == 3'h3) begin
         cls = ifd_pkg::IFD_LOAD_STORE;
         undef_next = w[4]; // [RULE13]
      end else if (w[27:25] == 3'h2) begin
         cls = ifd_pkg::IFD_LOAD_STORE;
      end else if (is_mult) begin
         cls = ifd_pkg::IFD_MULTIPLY;
      end else if (is_mlong) begin
         cls = ifd_pkg::IFD_MUL_LONG;
      end else if (is_swap) begin
         cls = ifd_pkg::IFD_SWAP;
      end else if (is_bx) begin
         cls = ifd_pkg::IFD_BRANCH_EXCH;
      end else if (is_half) begin
         cls = ifd_pkg::IFD_HALF_SIGNED;
      end else if (ifd_status_form(w, 5'h02, 2'h0)) begin
         cls = ifd_pkg::IFD_STATUS_READ; // [RULE3]
      end else if (ifd_status_form(w, 5'h06, 2'h2)) begin
         cls = ifd_pkg::IFD_STATUS_WR_IMM; // [RULE4]
      end else if (ifd_status_form(w, 5'h02, 2'h2) && !w[4]) begin
         cls = ifd_pkg::IFD_STATUS_WR_REG; // [RULE5]
      end else begin
         cls = ifd_pkg::IFD_DATA_PROC; // [RULE12]
      end
   end

   // Valid and class stage
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dec_valid <= 1'b0;
         dec_class <= ifd_pkg::IFD_DATA_PROC;
         undef_trap <= 1'b0;
         coproc_request <= 1'b0;
      end else begin
         dec_valid <= instr_valid;
         dec_class <= cls;
         undef_trap <= instr_valid && undef_next; // [RULE13]
         coproc_request <= instr_valid && ((w[27:25] == 3'h6) || (w[27:24] == 4'he)); // [RULE11]
      end
   end

   // Register fields, 4 bits each, index the 31-entry bank via mode banking
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cond_code <= ifd_pkg::IFD_REG_RESET;
         base_reg <= ifd_pkg::IFD_REG_RESET;
         dest_reg <= ifd_pkg::IFD_REG_RESET;
         operand_reg <= ifd_pkg::IFD_REG_RESET;
         shift_reg <= ifd_pkg::IFD_REG_RESET;
         coproc_id <= ifd_pkg::IFD_REG_RESET;
         coproc_dest <= ifd_pkg::IFD_REG_RESET;
      end else if (instr_valid) begin
         cond_code <= w[31:28];
         base_reg <= w[ifd_pkg::IFD_RN_LSB +: 4]; // [RULE10]
         dest_reg <= w[ifd_pkg::IFD_RD_LSB +: 4]; // [RULE3] [RULE10]
         operand_reg <= w[3:0]; // [RULE5]
         shift_reg <= w[11:8];
         coproc_id <= w[ifd_pkg::IFD_CPID_LSB +: 4]; // [RULE2] [RULE11]
         coproc_dest <= w[ifd_pkg::IFD_RD_LSB +: 4]; // [RULE2]
      end
   end

   // Operation flags and immediates
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         opcode <= 4'h0;
         imm_operand <= 1'b0;
         flag_update <= 1'b0;
         imm_value <= '0;
         branch_offset <= ifd_pkg::IFD_WORD_RESET;
         branch_and_save_return <= 1'b0;
         saved_status_select <= 1'b0;
         field_mask <= 4'h0;
         index_before_use <= 1'b0;
         add_offset_flag <= 1'b0;
         byte_or_size_flag <= 1'b0;
         base_update <= 1'b0;
         load_flag <= 1'b0;
         user_privilege_access <= 1'b0;
         coproc_offset <= 8'h00;
         reg_list <= 16'h0000;
      end else if (instr_valid) begin
         opcode <= w[24:21]; // [RULE12]
         imm_operand <= w[ifd_pkg::IFD_IMM_BIT]; // [RULE12]
         // Flag update only for data processing and both multiply kinds
         flag_update <= w[ifd_pkg::IFD_SBIT] && ((cls == ifd_pkg::IFD_DATA_PROC) ||
            (cls == ifd_pkg::IFD_MULTIPLY) || (cls == ifd_pkg::IFD_MUL_LONG)); // [RULE9]
         imm_value <= DATA_WIDTH'(ifd_rot_imm(w[11:0])); // [RULE6]
         // Word offset: sign-extend then scale by four
         branch_offset <= {{6{w[23]}}, w[23:0], 2'b00}; // [RULE1]
         branch_and_save_return <= (cls == ifd_pkg::IFD_BRANCH) && w[24]; // [RULE1]
         saved_status_select <= w[ifd_pkg::IFD_SPSR_BIT]; // [RULE3] [RULE4]
         field_mask <= w[19:16]; // [RULE4] [RULE5]
         index_before_use <= w[24];
         add_offset_flag <= w[23];
         byte_or_size_flag <= w[22];
         base_update <= w[21];
         load_flag <= w[20];
         // Post-indexed with write-back bit means user translation
         user_privilege_access <= (w[27:26] == 2'h1) && !w[24] && w[21]; // [RULE8]
         coproc_offset <= w[7:0]; // [RULE2]
         reg_list <= w[15:0];
      end
   end

   // Checks; each output is held against the word taken one edge before
   a_branch_link_bit: assert property (@(posedge clk_sys) disable iff (reset) // [RULE1]
      instr_valid && w[27:25] == 3'h5 |=> branch_and_save_return == $past(w[24]))
      else $error("branch link flag wrong");
   a_branch_class: assert property (@(posedge clk_sys) disable iff (reset) // [RULE1]
      instr_valid && w[27:25] == 3'h5 |=> dec_class == ifd_pkg::IFD_BRANCH)
      else $error("branch misdecoded");
   a_branch_offset_ext: assert property (@(posedge clk_sys) disable iff (reset) // [RULE1]
      instr_valid |=> branch_offset[31:26] == {6{$past(w[23])}})
      else $error("branch offset not sign extended");
   a_coproc_ls_class: assert property (@(posedge clk_sys) disable iff (reset) // [RULE2]
      instr_valid && w[27:25] == 3'h6 |=> dec_class == ifd_pkg::IFD_COPROC_LS
      && coproc_request && coproc_id == $past(w[11:8]))
      else $error("coprocessor load store misdecoded");
   a_coproc_ls_fields: assert property (@(posedge clk_sys) disable iff (reset) // [RULE2]
      instr_valid && w[27:25] == 3'h6 |=> coproc_offset == $past(w[7:0])
      && coproc_dest == $past(w[15:12]) && base_reg == $past(w[19:16]))
      else $error("coprocessor load store fields wrong");
   a_status_read: assert property (@(posedge clk_sys) disable iff (reset) // [RULE3]
      instr_valid && w[27:23] == 5'h02 && w[21:20] == 2'h0 && w[11:0] == 12'h000 |=>
      dec_class == ifd_pkg::IFD_STATUS_READ && saved_status_select == $past(w[22])
      && dest_reg == $past(w[15:12]))
      else $error("status read misdecoded");
   a_status_wr_imm: assert property (@(posedge clk_sys) disable iff (reset) // [RULE4]
      instr_valid && w[27:23] == 5'h06 && w[21:20] == 2'h2 |=>
      dec_class == ifd_pkg::IFD_STATUS_WR_IMM && field_mask == $past(w[19:16]))
      else $error("status immediate write misdecoded");
   a_status_wr_reg: assert property (@(posedge clk_sys) disable iff (reset) // [RULE5]
      instr_valid && w[27:23] == 5'h02 && w[21:20] == 2'h2 && w[7:4] == 4'h0 |=>
      dec_class == ifd_pkg::IFD_STATUS_WR_REG && operand_reg == $past(w[3:0]))
      else $error("status register write misdecoded");
   a_rot_imm_value: assert property (@(posedge clk_sys) disable iff (reset) // [RULE6]
      instr_valid && w[11:8] == 4'h1 |=>
      imm_value == {$past(w[1:0]), 24'h00_0000, $past(w[7:2])})
      else $error("rotated immediate wrong");
   a_rot_imm_plain: assert property (@(posedge clk_sys) disable iff (reset) // [RULE6]
      instr_valid && w[11:8] == 4'h0 |=> imm_value == {24'h00_0000, $past(w[7:0])})
      else $error("unrotated immediate wrong");
   a_mult_bit6_quiet: assert property (@(posedge clk_sys) disable iff (reset) // [RULE7]
      instr_valid && w[27:22] == 6'h00 && w[7:4] == 4'hd |=>
      dec_class == ifd_pkg::IFD_MULTIPLY && !undef_trap)
      else $error("unallocated multiply misdecoded");
   a_user_post_only: assert property (@(posedge clk_sys) disable iff (reset) // [RULE8]
      instr_valid && w[24] |=> !user_privilege_access)
      else $error("user access with pre-index");
   a_user_translate: assert property (@(posedge clk_sys) disable iff (reset) // [RULE8]
      instr_valid && w[27:26] == 2'h1 && !w[24] && w[21] |=> user_privilege_access)
      else $error("user translation not requested");
   a_flag_update: assert property (@(posedge clk_sys) disable iff (reset) // [RULE9]
      instr_valid && !w[20] |=> !flag_update)
      else $error("flag update without bit 20");
   a_flag_update_set: assert property (@(posedge clk_sys) disable iff (reset) // [RULE9]
      instr_valid && w[27:25] == 3'h1 && w[20] |=> flag_update)
      else $error("flag update missing");
   a_mult_flag: assert property (@(posedge clk_sys) disable iff (reset) // [RULE9]
      instr_valid && w[27:22] == 6'h00 && w[7:4] == 4'h9 |=> flag_update == $past(w[20]))
      else $error("multiply flag update wrong");
   a_reg_field: assert property (@(posedge clk_sys) disable iff (reset) // [RULE10]
      instr_valid |=> base_reg == $past(w[19:16]) && REG_COUNT == 31)
      else $error("base register field wrong");
   a_coproc_routed: assert property (@(posedge clk_sys) disable iff (reset) // [RULE11]
      instr_valid && w[27:24] == 4'he |=> coproc_request ##0 dec_valid)
      else $error("coprocessor op not routed");
   a_coproc_data_class: assert property (@(posedge clk_sys) disable iff (reset) // [RULE11]
      instr_valid && w[27:24] == 4'he && !w[4] |=> dec_class == ifd_pkg::IFD_COPROC_DATA
      && coproc_id == $past(w[11:8]))
      else $error("coprocessor data op misdecoded");
   a_coproc_xfer_class: assert property (@(posedge clk_sys) disable iff (reset) // [RULE11]
      instr_valid && w[27:24] == 4'he && w[4] |=> dec_class == ifd_pkg::IFD_COPROC_XFER
      && coproc_id == $past(w[11:8]))
      else $error("coprocessor transfer misdecoded");
   a_dp_fallback: assert property (@(posedge clk_sys) disable iff (reset) // [RULE12]
      instr_valid && w[27:25] == 3'h1 && w[24:23] != 2'h2 |=>
      dec_class == ifd_pkg::IFD_DATA_PROC)
      else $error("data processing misdecoded");
   a_dp_opcode: assert property (@(posedge clk_sys) disable iff (reset) // [RULE12]
      instr_valid && w[27:25] == 3'h1 |=> opcode == $past(w[24:21]) && imm_operand)
      else $error("data processing opcode wrong");
   a_undef_trap: assert property (@(posedge clk_sys) disable iff (reset) // [RULE13]
      instr_valid && w[27:25] == 3'h3 |=> undef_trap == $past(w[4]))
      else $error("undefined trap mismatch");
   a_undef_elsewhere: assert property (@(posedge clk_sys) disable iff (reset) // [RULE13]
      instr_valid && w[27:25] != 3'h3 |=> !undef_trap)
      else $error("undefined trap on defined word");
   a_ls_reg_class: assert property (@(posedge clk_sys) disable iff (reset) // [RULE13]
      instr_valid && w[27:25] == 3'h3 && !w[4] |=> dec_class == ifd_pkg::IFD_LOAD_STORE
      && operand_reg == $past(w[3:0]))
      else $error("register offset load store misdecoded");

   c_branch_link: cover property (@(posedge clk_sys) disable iff (reset)
      dec_valid && branch_and_save_return);
   c_undef: cover property (@(posedge clk_sys) disable iff (reset) undef_trap);
   c_coproc_xfer: cover property (@(posedge clk_sys) disable iff (reset)
      dec_valid && dec_class == ifd_pkg::IFD_COPROC_XFER);
   c_status_imm: cover property (@(posedge clk_sys) disable iff (reset)
      dec_valid && dec_class == ifd_pkg::IFD_STATUS_WR_IMM);
   c_multiply: cover property (@(posedge clk_sys) disable iff (reset)
      dec_valid && dec_class == ifd_pkg::IFD_MULTIPLY);

endmodule : ifd_decoder
`default_nettype wire

// ==== sim/ifd_decoder_tb.sv ====
// Self-checking bench for the instruction format decoder
`default_nettype none
module ifd_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, reset, instr_valid;
   logic [31:0] instr_word, imm_value, branch_offset;
   logic dec_valid, imm_operand, flag_update, branch_and_save_return, saved_status_select;
   logic index_before_use, add_offset_flag, byte_or_size_flag, base_update, load_flag;
   logic user_privilege_access, coproc_request, undef_trap;
   logic [3:0] opcode, base_reg, dest_reg, operand_reg, field_mask, coproc_id, coproc_dest;
   logic [7:0] coproc_offset;
   logic [3:0] cond_code, shift_reg;
   logic [15:0] reg_list;
   ifd_pkg::ifd_class_t dec_class;
   int fails = 0;
   int n_tests = 0;

   ifd_decoder ifd_decoder_inst (.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid),
      .instr_word(instr_word), .dec_valid(dec_valid), .dec_class(dec_class),
      .cond_code(cond_code),
      .opcode(opcode), .imm_operand(imm_operand), .flag_update(flag_update),
      .base_reg(base_reg), .dest_reg(dest_reg), .operand_reg(operand_reg),
      .shift_reg(shift_reg),
      .imm_value(imm_value), .branch_offset(branch_offset),
      .branch_and_save_return(branch_and_save_return),
      .saved_status_select(saved_status_select), .field_mask(field_mask),
      .index_before_use(index_before_use), .add_offset_flag(add_offset_flag),
      .byte_or_size_flag(byte_or_size_flag), .base_update(base_update),
      .load_flag(load_flag), .user_privilege_access(user_privilege_access),
      .coproc_id(coproc_id), .coproc_dest(coproc_dest), .coproc_offset(coproc_offset),
      .coproc_request(coproc_request), .reg_list(reg_list), .undef_trap(undef_trap));

   // 25 MHz core clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // One comparison; case equality so an unknown never matches
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic chk_cls(input ifd_pkg::ifd_class_t exp);
      chk("dec_class", {28'h0, dec_class}, {28'h0, exp});
   endtask : chk_cls

   // Present one word; outputs land one edge later, sampled 1 ns after it
   task automatic dec(input logic [31:0] w);
      instr_valid = 1'b1;
      instr_word = w;
      @(posedge clk_sys);
      #1;
      chk("dec_valid", {31'h0, dec_valid}, 32'h1);
   endtask : dec

   // Idle cycle; valid is a pulse, so it must drop with no new word
   task automatic idle();
      instr_valid = 1'b0;
      @(posedge clk_sys);
      #1;
      chk("dec_valid", {31'h0, dec_valid}, 32'h0);
   endtask : idle

   task automatic t_branch();
      dec(32'heb000001);
      chk_cls(ifd_pkg::IFD_BRANCH);
      chk("save_ret", {31'h0, branch_and_save_return}, 32'h1);
      chk("br_ofs", branch_offset, 32'h4);
      dec(32'heafffffe);
      chk("save_ret", {31'h0, branch_and_save_return}, 32'h0);
      chk("br_ofs", branch_offset, 32'hfffffff8);
      idle();
   endtask : t_branch

   task automatic t_coproc();
      dec(32'hed93572a);
      chk_cls(ifd_pkg::IFD_COPROC_LS);
      chk("flags", {27'h0, index_before_use, add_offset_flag, byte_or_size_flag,
         base_update, load_flag}, 32'h19);
      chk("regs", {20'h0, base_reg, coproc_dest, coproc_id}, 32'h357);
      chk("cp_ofs", {24'h0, coproc_offset}, 32'h2a);
      chk("cp_req", {31'h0, coproc_request}, 32'h1);
      dec(32'hee012a03);
      chk_cls(ifd_pkg::IFD_COPROC_DATA);
      chk("cp_id", {28'h0, coproc_id}, 32'ha);
      dec(32'hee112b13);
      chk_cls(ifd_pkg::IFD_COPROC_XFER);
      chk("cp_id", {28'h0, coproc_id}, 32'hb);
      chk("cp_req", {31'h0, coproc_request}, 32'h1);
      idle();
      chk("cp_req", {31'h0, coproc_request}, 32'h0);
   endtask : t_coproc

   task automatic t_status();
      dec(32'he14f3000);
      chk_cls(ifd_pkg::IFD_STATUS_READ);
      chk("saved", {31'h0, saved_status_select}, 32'h1);
      chk("dest", {28'h0, dest_reg}, 32'h3);
      chk("base", {28'h0, base_reg}, 32'hf);
      dec(32'he329f4ff);
      chk_cls(ifd_pkg::IFD_STATUS_WR_IMM);
      chk("saved", {31'h0, saved_status_select}, 32'h0);
      chk("mask", {28'h0, field_mask}, 32'h9);
      chk("imm", imm_value, 32'hff000000);
      dec(32'he16ff005);
      chk_cls(ifd_pkg::IFD_STATUS_WR_REG);
      chk("src", {28'h0, operand_reg}, 32'h5);
      chk("mask", {28'h0, field_mask}, 32'hf);
      idle();
   endtask : t_status

   task automatic t_dataproc();
      dec(32'he2912003);
      chk_cls(ifd_pkg::IFD_DATA_PROC);
      chk("op", {26'h0, opcode, imm_operand, flag_update}, 32'h13);
      chk("imm", imm_value, 32'h3);
      dec(32'he3a00f81);
      chk("imm", imm_value, 32'h204);
      chk("op", {26'h0, opcode, imm_operand, flag_update}, 32'h36);
      dec(32'he0812003);
      chk("op", {26'h0, opcode, imm_operand, flag_update}, 32'h10);
      dec(32'he01002d1);
      chk_cls(ifd_pkg::IFD_MULTIPLY);
      chk("trap", {31'h0, undef_trap}, 32'h0);
      chk("flags", {31'h0, flag_update}, 32'h1);
      idle();
   endtask : t_dataproc

   // Remaining classes, plus condition, shift register and list fields
   task automatic t_classes();
      dec(32'h1f123456);
      chk_cls(ifd_pkg::IFD_SOFT_INT);
      chk("cond", {28'h0, cond_code}, 32'h1);
      dec(32'he8bd400f);
      chk_cls(ifd_pkg::IFD_LOAD_STORE_MULT);
      chk("list", {16'h0, reg_list}, 32'h400f);
      dec(32'he1021093);
      chk_cls(ifd_pkg::IFD_SWAP);
      dec(32'he12fff1e);
      chk_cls(ifd_pkg::IFD_BRANCH_EXCH);
      chk("rm", {28'h0, operand_reg}, 32'he);
      dec(32'he1d320b4);
      chk_cls(ifd_pkg::IFD_HALF_SIGNED);
      dec(32'he0921394);
      chk_cls(ifd_pkg::IFD_MUL_LONG);
      chk("flags", {31'h0, flag_update}, 32'h1);
      chk("rs", {28'h0, shift_reg}, 32'h3);
      idle();
   endtask : t_classes

   // Reset in mid-run; class was long multiply before, so a clear is visible
   task automatic t_reset();
      reset = 1'b1;
      @(posedge clk_sys);
      #1;
      chk_cls(ifd_pkg::IFD_DATA_PROC);
      chk("rst_ofs", branch_offset, 32'h0);
      chk("rst_fields", {16'h0, cond_code, base_reg, operand_reg, field_mask}, 32'h0);
      chk("rst_valid", {30'h0, dec_valid, coproc_request}, 32'h0);
      reset = 1'b0;
   endtask : t_reset

   task automatic t_loadstore();
      dec(32'he4b21004);
      chk_cls(ifd_pkg::IFD_LOAD_STORE);
      chk("user", {31'h0, user_privilege_access}, 32'h1);
      dec(32'he5b21004);
      chk("user", {31'h0, user_privilege_access}, 32'h0);
      dec(32'he6000010);
      chk("trap", {31'h0, undef_trap}, 32'h1);
      dec(32'he7921003);
      chk_cls(ifd_pkg::IFD_LOAD_STORE);
      chk("trap", {31'h0, undef_trap}, 32'h0);
      chk("rm", {28'h0, operand_reg}, 32'h3);
      idle();
      chk("rm", {28'h0, operand_reg}, 32'h3);
   endtask : t_loadstore

   // Prints the counts and the verdict, then ends the run
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   // Watchdog so a stuck run still reaches the report
   initial begin
      repeat (2000) @(posedge clk_sys);
      fails++;
      final_report();
   end

   initial begin
      reset = 1'b1;
      instr_valid = 1'b0;
      instr_word = 32'h0;
      repeat (10) @(posedge clk_sys);
      #1;
      chk_cls(ifd_pkg::IFD_DATA_PROC);
      reset = 1'b0;
      t_branch();
      t_coproc();
      t_status();
      t_dataproc();
      t_classes();
      t_reset();
      t_loadstore();
      final_report();
   end
endmodule : ifd_decoder_tb
`default_nettype wire
